// *** include/dce_pkg.sv ***
// package of constants and carriers for the dma channel event and crc control block
`default_nettype none

package dce_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CRC_CTRL  = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;
    localparam logic [7:0] OFS_CHAN_EN   = 8'h10;
    localparam logic [7:0] OFS_CHAN_BUSY = 8'h14;
    localparam logic [7:0] OFS_ECR_BASE  = 8'h40;

    // ************************************************************
    // channel event control fields
    // ************************************************************
    localparam int unsigned ECR_ABORT_SEL_LSB = 16;
    localparam int unsigned ECR_START_SEL_LSB = 8;
    localparam int unsigned ECR_FORCE_BIT     = 7;
    localparam int unsigned ECR_SWABORT_BIT   = 6;
    localparam int unsigned ECR_PAT_EN_BIT    = 5;
    localparam int unsigned ECR_SIRQ_EN_BIT   = 4;
    localparam int unsigned ECR_AIRQ_EN_BIT   = 3;
    localparam logic [7:0]  ECR_SEL_RESET     = 8'hff;

    // ************************************************************
    // crc control fields
    // ************************************************************
    localparam int unsigned CRC_BYTE_ORDER_BIT = 7;
    localparam int unsigned CRC_APPEND_BIT     = 6;
    localparam int unsigned CRC_TYPE_BIT       = 5;
    localparam int unsigned CRC_CHAN_LSB       = 0;
    localparam int unsigned CRC_CHAN_W         = 3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] abort_irq_select;
        logic [7:0] start_irq_select;
        logic       pattern_abort_enable;
        logic       start_irq_enable;
        logic       abort_irq_enable;
    } dce_ecr_type;

    typedef struct packed {
        logic       byte_order_option;
        logic       crc_append_mode;
        logic       crc_type_select;
        logic [2:0] crc_channel_select;
    } dce_crc_type;

    localparam dce_ecr_type ECR_RESET = '{ECR_SEL_RESET, ECR_SEL_RESET, 1'b0, 1'b0, 1'b0};
    localparam dce_crc_type CRC_RESET = '{1'b0, 1'b0, 1'b0, 3'h0};

endpackage

`default_nettype wire

// *** logic/dce_event_ctrl.sv ***
// dma channel trigger, abort and crc attachment control with wishbone register access
`default_nettype none

module dce_event_ctrl #(
    parameter int unsigned NUM_CH = 8
) (
    input  wire  logic                 clk_sys_i,
    input  wire  logic                 resetn_i,
    input  wire  logic                 wb_cyc_i,
    input  wire  logic                 wb_stb_i,
    input  wire  logic                 wb_we_i,
    input  wire  logic [7:0]           wb_adr_i,
    input  wire  logic [3:0]           wb_sel_i,
    input  wire  logic [31:0]          wb_dat_i,
    output logic       [31:0]          wb_dat_o,
    output logic                       wb_ack_o,
    input  wire  logic                 irq_valid_i,
    input  wire  logic [7:0]           irq_num_i,
    input  wire  logic [NUM_CH-1:0]    pattern_match_i,
    input  wire  logic [NUM_CH-1:0]    block_done_i,
    input  wire  logic                 src_valid_i,
    input  wire  logic [2:0]           src_chan_i,
    input  wire  logic [31:0]          src_data_i,
    input  wire  logic                 src_aligned_i,
    input  wire  logic [31:0]          crc_result_i,
    input  wire  logic [31:0]          dest_start_addr_i,
    output logic       [NUM_CH-1:0]    start_o,
    output logic       [NUM_CH-1:0]    abort_o,
    output logic       [NUM_CH-1:0]    channel_enable_o,
    output logic       [NUM_CH-1:0]    busy_o,
    output logic                       crc_valid_o,
    output logic       [31:0]          crc_data_o,
    output logic                       crc_type_o,
    output logic                       dst_valid_o,
    output logic       [31:0]          dst_data_o,
    output logic                       dst_at_start_o,
    output logic       [31:0]          dst_addr_o,
    output logic                       unaligned_err_o,
    output logic                       irq_o
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 8");
    end

    localparam int unsigned SW = 2 * NUM_CH;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] ecr_word(input dce_pkg::dce_ecr_type e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[dce_pkg::ECR_ABORT_SEL_LSB +: 8]  = e.abort_irq_select;
        w[dce_pkg::ECR_START_SEL_LSB +: 8]  = e.start_irq_select;
        w[dce_pkg::ECR_PAT_EN_BIT]          = e.pattern_abort_enable;
        w[dce_pkg::ECR_SIRQ_EN_BIT]         = e.start_irq_enable;
        w[dce_pkg::ECR_AIRQ_EN_BIT]         = e.abort_irq_enable;
        return w;
    endfunction

    function automatic logic [31:0] crc_word(input dce_pkg::dce_crc_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[dce_pkg::CRC_BYTE_ORDER_BIT]                        = c.byte_order_option;
        w[dce_pkg::CRC_APPEND_BIT]                            = c.crc_append_mode;
        w[dce_pkg::CRC_TYPE_BIT]                              = c.crc_type_select;
        w[dce_pkg::CRC_CHAN_LSB +: dce_pkg::CRC_CHAN_W]       = c.crc_channel_select;
        return w;
    endfunction

    function automatic logic [31:0] swap_bytes(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    logic                        ack_r;
    logic [31:0]                 rdata_r;
    dce_pkg::dce_ecr_type        ecr_r [NUM_CH];
    dce_pkg::dce_crc_type        crc_r;
    logic [NUM_CH-1:0]           chan_en_r;
    logic [NUM_CH-1:0]           busy_r;
    logic [SW-1:0]               stat_r;
    logic [SW-1:0]               irq_en_r;

    wire        bus_go     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr_go      = bus_go & wb_we_i;
    wire        hit_crc    = (wb_adr_i == dce_pkg::OFS_CRC_CTRL);
    wire        hit_stat   = (wb_adr_i == dce_pkg::OFS_IRQ_STAT);
    wire        hit_clr    = (wb_adr_i == dce_pkg::OFS_IRQ_CLR);
    wire        hit_en     = (wb_adr_i == dce_pkg::OFS_IRQ_EN);
    wire        hit_channel_enable   = (wb_adr_i == dce_pkg::OFS_CHAN_EN);
    wire        hit_busy   = (wb_adr_i == dce_pkg::OFS_CHAN_BUSY);
    wire        hit_ecr    = (wb_adr_i[7:5] == dce_pkg::OFS_ECR_BASE[7:5]) && (32'(wb_adr_i[4:2]) < NUM_CH);
    wire [2:0]  ecr_idx    = wb_adr_i[4:2];

    // ************************************************************
    // read data selection
    // ************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_crc) begin
            rd_mux = crc_word(crc_r);
        end else if (hit_stat) begin
            rd_mux[SW-1:0] = stat_r;
        end else if (hit_en) begin
            rd_mux[SW-1:0] = irq_en_r;
        end else if (hit_channel_enable) begin
            rd_mux[NUM_CH-1:0] = chan_en_r;
        end else if (hit_busy) begin
            rd_mux[NUM_CH-1:0] = busy_r;
        end else if (hit_ecr) begin
            rd_mux = ecr_word(ecr_r[ecr_idx]);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= bus_go;
            rdata_r <= bus_go ? rd_mux : 32'h0000_0000;
        end
    end

    // ************************************************************
    // crc control register
    // ************************************************************
    wire [31:0]           crc_wr_word = lane_merge(crc_word(crc_r), wb_dat_i, wb_sel_i);
    dce_pkg::dce_crc_type crc_nxt;
    always_comb begin
        crc_nxt = crc_r;
        if (wr_go && hit_crc) begin
            crc_nxt.byte_order_option  = crc_wr_word[dce_pkg::CRC_BYTE_ORDER_BIT];
            crc_nxt.crc_type_select    = crc_wr_word[dce_pkg::CRC_TYPE_BIT];
            crc_nxt.crc_channel_select = crc_wr_word[dce_pkg::CRC_CHAN_LSB +: dce_pkg::CRC_CHAN_W];
            crc_nxt.crc_append_mode    = crc_wr_word[dce_pkg::CRC_APPEND_BIT]
                                         & ~crc_wr_word[dce_pkg::CRC_BYTE_ORDER_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_r <= dce_pkg::CRC_RESET;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    // ************************************************************
    // per-channel trigger logic
    // ************************************************************
    wire [31:0]        ecr_wr_raw = wb_dat_i;
    logic [NUM_CH-1:0] start_go;
    logic [NUM_CH-1:0] abort_go;
    logic [NUM_CH-1:0] channel_enable_wr_val;
    wire               channel_enable_wr = wr_go & hit_channel_enable;
    wire  [31:0]       channel_enable_word = lane_merge({{(32-NUM_CH){1'b0}}, chan_en_r}, wb_dat_i, wb_sel_i);
    assign channel_enable_wr_val = channel_enable_word[NUM_CH-1:0];

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        wire         ecr_wr    = wr_go && hit_ecr && (32'(ecr_idx) == ch);
        wire [31:0]  ecr_merge = lane_merge(ecr_word(ecr_r[ch]), ecr_wr_raw, wb_sel_i);
        wire         force_hit = ecr_wr & wb_sel_i[0] & ecr_wr_raw[dce_pkg::ECR_FORCE_BIT];
        wire         swab_hit  = ecr_wr & wb_sel_i[0] & ecr_wr_raw[dce_pkg::ECR_SWABORT_BIT];
        wire         irq_start = irq_valid_i && ecr_r[ch].start_irq_enable
                                 && (irq_num_i == ecr_r[ch].start_irq_select);
        wire         irq_abort = irq_valid_i && ecr_r[ch].abort_irq_enable
                                 && (irq_num_i == ecr_r[ch].abort_irq_select);
        wire         pat_abort = ecr_r[ch].pattern_abort_enable & pattern_match_i[ch];
        wire         en_now    = channel_enable_wr ? channel_enable_wr_val[ch] : chan_en_r[ch];

        assign abort_go[ch] = swab_hit | irq_abort | pat_abort;
        assign start_go[ch] = en_now & (force_hit | irq_start) & ~abort_go[ch];

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ecr_r[ch] <= dce_pkg::ECR_RESET;
            end else if (ecr_wr) begin
                ecr_r[ch].abort_irq_select     <= ecr_merge[dce_pkg::ECR_ABORT_SEL_LSB +: 8];
                ecr_r[ch].start_irq_select     <= ecr_merge[dce_pkg::ECR_START_SEL_LSB +: 8];
                ecr_r[ch].pattern_abort_enable <= ecr_merge[dce_pkg::ECR_PAT_EN_BIT];
                ecr_r[ch].start_irq_enable     <= ecr_merge[dce_pkg::ECR_SIRQ_EN_BIT];
                ecr_r[ch].abort_irq_enable     <= ecr_merge[dce_pkg::ECR_AIRQ_EN_BIT];
            end
        end

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                chan_en_r[ch] <= 1'b0;
            end else if (pat_abort) begin
                chan_en_r[ch] <= 1'b0;
            end else if (channel_enable_wr) begin
                chan_en_r[ch] <= channel_enable_wr_val[ch];
            end
        end

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                busy_r[ch] <= 1'b0;
            end else if (abort_go[ch]) begin
                busy_r[ch] <= 1'b0;
            end else if (start_go[ch]) begin
                busy_r[ch] <= 1'b1;
            end else if (block_done_i[ch]) begin
                busy_r[ch] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // interrupt status, clear and enable
    // ************************************************************
    logic [NUM_CH-1:0] abort_flag_set;
    assign abort_flag_set = abort_go & (busy_r | start_go);

    wire [SW-1:0]  stat_set  = {block_done_i & busy_r, abort_flag_set};
    wire [31:0]    clr_word  = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [SW-1:0]  stat_clr  = (wr_go && hit_clr) ? clr_word[SW-1:0] : {SW{1'b0}};
    wire [SW-1:0]  stat_nxt  = (stat_r & ~stat_clr) | stat_set;
    wire [31:0]    en_word   = lane_merge({{(32-SW){1'b0}}, irq_en_r}, wb_dat_i, wb_sel_i);
    wire [SW-1:0]  en_nxt    = (wr_go && hit_en) ? en_word[SW-1:0] : irq_en_r;

    logic irq_r;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_r   <= {SW{1'b0}};
            irq_en_r <= {SW{1'b0}};
            irq_r    <= 1'b0;
        end else begin
            stat_r   <= stat_nxt;
            irq_en_r <= en_nxt;
            irq_r    <= |(stat_nxt & en_nxt);
        end
    end

    // ************************************************************
    // crc data path
    // ************************************************************
    wire       crc_chan_hit = src_valid_i && (src_chan_i == crc_r.crc_channel_select);
    wire       append_done  = crc_r.crc_append_mode && (32'(crc_r.crc_channel_select) < NUM_CH)
                              && block_done_i[crc_r.crc_channel_select];
    wire       unaligned    = crc_chan_hit & crc_r.byte_order_option & ~src_aligned_i;
    wire       pass_dst     = src_valid_i & ~unaligned & ~(crc_chan_hit & crc_r.crc_append_mode);
    wire [31:0] pass_data   = (crc_chan_hit && crc_r.byte_order_option) ? swap_bytes(src_data_i)
                                                                        : src_data_i;

    logic        crc_valid_r;
    logic [31:0] crc_data_r;
    logic        dst_valid_r;
    logic [31:0] dst_data_r;
    logic        dst_start_r;
    logic [31:0] dst_addr_r;
    logic        unal_r;
    logic [NUM_CH-1:0] start_r;
    logic [NUM_CH-1:0] abort_r;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_valid_r <= 1'b0;
            crc_data_r  <= 32'h0000_0000;
            unal_r      <= 1'b0;
            start_r     <= {NUM_CH{1'b0}};
            abort_r     <= {NUM_CH{1'b0}};
        end else begin
            crc_valid_r <= crc_chan_hit & ~unaligned;
            crc_data_r  <= src_data_i;
            unal_r      <= unaligned;
            start_r     <= start_go;
            abort_r     <= abort_go;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dst_valid_r <= 1'b0;
            dst_data_r  <= 32'h0000_0000;
            dst_start_r <= 1'b0;
            dst_addr_r  <= 32'h0000_0000;
        end else if (append_done) begin
            dst_valid_r <= 1'b1;
            dst_data_r  <= crc_result_i;
            dst_start_r <= 1'b1;
            dst_addr_r  <= dest_start_addr_i;
        end else begin
            dst_valid_r <= pass_dst;
            dst_data_r  <= pass_data;
            dst_start_r <= 1'b0;
            dst_addr_r  <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_ack_o         = ack_r;
    assign wb_dat_o         = rdata_r;
    assign start_o          = start_r;
    assign abort_o          = abort_r;
    assign channel_enable_o = chan_en_r;
    assign busy_o           = busy_r;
    assign crc_valid_o      = crc_valid_r;
    assign crc_data_o       = crc_data_r;
    assign crc_type_o       = crc_r.crc_type_select;
    assign dst_valid_o      = dst_valid_r;
    assign dst_data_o       = dst_data_r;
    assign dst_at_start_o   = dst_start_r;
    assign dst_addr_o       = dst_addr_r;
    assign unaligned_err_o  = unal_r;
    assign irq_o            = irq_r;

endmodule // dce_event_ctrl

`default_nettype wire

// *** dv/dce_event_ctrl_properties.sv ***
// assertion checker for the event and crc control block
`default_nettype none
module dce_chk #(
    parameter int unsigned NUM_CH = 8
) (
    input wire logic              clk_sys_i,
    input wire logic              resetn_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [31:0]       crc_result_i,
    input wire logic [31:0]       dest_start_addr_i,
    input wire logic [NUM_CH-1:0] start_o,
    input wire logic [NUM_CH-1:0] abort_o,
    input wire logic [NUM_CH-1:0] busy_o,
    input wire logic              crc_valid_o,
    input wire logic              crc_type_o,
    input wire logic              dst_valid_o,
    input wire logic              dst_at_start_o,
    input wire logic [31:0]       dst_data_o,
    input wire logic [31:0]       dst_addr_o,
    input wire logic              unaligned_err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_drops: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ecr_zero_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h40 && wb_adr_i < 8'h60
        |-> wb_dat_o[31:24] == 8'h00 && wb_dat_o[7:6] == 2'h0 && wb_dat_o[2:0] == 3'h0)
        else $error("event control unused bits not zero");
    a_crc_zero_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[4:3] == 2'h0)
        else $error("crc control bits 4-3 not zero");
    a_start_sets_busy: assert property (|start_o |-> (start_o & ~busy_o) == '0)
        else $error("start without busy");
    a_abort_ends_busy: assert property (|abort_o |-> (abort_o & busy_o) == '0)
        else $error("busy after abort");
    a_abort_wins: assert property ((start_o & abort_o) == '0)
        else $error("start and abort together");
    a_dst_crc_word: assert property (dst_valid_o && dst_at_start_o
        |-> dst_data_o == $past(crc_result_i) && dst_addr_o == $past(dest_start_addr_i))
        else $error("crc write wrong");
    a_unaligned_drop: assert property (unaligned_err_o |-> !crc_valid_o && !dst_valid_o)
        else $error("unaligned word passed");
    a_type_follows: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
        |=> crc_type_o == $past(wb_dat_i[5]))
        else $error("crc type not applied");
endmodule // dce_chk
bind dce_event_ctrl dce_chk #(.NUM_CH(NUM_CH)) i_dce_chk (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .crc_result_i, .dest_start_addr_i,
    .start_o, .abort_o, .busy_o, .crc_valid_o, .crc_type_o, .dst_valid_o, .dst_at_start_o, .dst_data_o,
    .dst_addr_o, .unaligned_err_o);
`default_nettype wire

// *** dv/dce_irq_src.sv ***
// interrupt source and crc engine stand-in facing the block
`default_nettype none
module dce_irq_src (
    input  wire logic        clk_sys_i,
    output logic             irq_valid_o,
    output logic [7:0]       irq_num_o,
    output logic [31:0]      crc_result_o,
    output logic [31:0]      dest_start_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign crc_result_o      = 32'h5a3c_96e1;
    assign dest_start_addr_o = 32'h0000_1000;
    initial begin
        irq_valid_o = 1'b0;
        irq_num_o   = 8'h00;
    end
    // one interrupt pulse; number line inverted while idle
    task automatic fire(input logic [7:0] num);
        @(posedge clk_sys_i);
        irq_valid_o <= 1'b1;
        irq_num_o   <= num;
        @(posedge clk_sys_i);
        irq_valid_o <= 1'b0;
        irq_num_o   <= ~num;
    endtask
endmodule // dce_irq_src
`default_nettype wire

// *** dv/tb_dce_event_ctrl.sv ***
// self-checking bench for the event and crc control block
`default_nettype none
module tb_dce_event_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, irq_valid_i, src_valid_i, src_aligned_i;
    logic        wb_ack_o, crc_valid_o, crc_type_o, dst_valid_o, dst_at_start_o, unaligned_err_o, irq_o, clr;
    logic [2:0]  src_chan_i;
    logic [3:0]  wb_sel_i, flg, sl;
    logic [7:0]  wb_adr_i, irq_num_i, pattern_match_i, block_done_i, st, ab, ra;
    logic [7:0]  start_o, abort_o, channel_enable_o, busy_o;
    logic [31:0] wb_dat_i, wb_dat_o, src_data_i, crc_result_i, dest_start_addr_i, dst_data_o, dst_addr_o;
    logic [31:0] dst_last, crc_last, crc_data_o, q, rw, rx;
    logic [71:0] rows [7];
    int          bad_count, compares;
    dce_event_ctrl #(.NUM_CH(8)) i_dce_event_ctrl (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_valid_i, .irq_num_i, .pattern_match_i,
        .block_done_i, .src_valid_i, .src_chan_i, .src_data_i, .src_aligned_i, .crc_result_i,
        .dest_start_addr_i, .start_o, .abort_o, .channel_enable_o, .busy_o, .crc_valid_o, .crc_data_o,
        .crc_type_o, .dst_valid_o, .dst_data_o, .dst_at_start_o, .dst_addr_o, .unaligned_err_o, .irq_o);
    dce_irq_src i_dce_irq_src (.clk_sys_i, .irq_valid_o(irq_valid_i), .irq_num_o(irq_num_i),
        .crc_result_o(crc_result_i), .dest_start_addr_o(dest_start_addr_i));
    // ****************************************
    // clock, monitor and tasks
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (clr) begin
            st  <= '0;
            ab  <= '0;
            flg <= '0;
        end else begin
            st  <= st | start_o;
            ab  <= ab | abort_o;
            flg <= flg | {unaligned_err_o, dst_valid_o & dst_at_start_o, dst_valid_o, crc_valid_o};
            if (dst_valid_o) dst_last <= dst_data_o;
            if (crc_valid_o) crc_last <= crc_data_o;
        end
    end
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, sl, d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (n >= 20) begin
            chk("bus ack", 32'h0, 32'h1);
            give_verdict();
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic clear_seen();
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
    endtask
    task automatic feed(input logic [31:0] d, input logic al);
        @(posedge clk_sys_i);
        {src_valid_i, src_data_i, src_aligned_i} <= {1'b1, d, al};
        @(posedge clk_sys_i);
        {src_valid_i, src_data_i} <= {1'b0, ~d};
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, src_valid_i, src_aligned_i, clr} = '0;
        {wb_adr_i, pattern_match_i, block_done_i, src_chan_i, wb_dat_i, src_data_i} = '0;
        wb_sel_i = 4'hf;
        sl = 4'hf;
        rows = '{{8'h00, 32'h0000_00ff, 32'h0000_00a7}, {8'h00, 32'h0000_0065, 32'h0000_0065},
                 {8'h40, 32'hffab_cdff, 32'h00ab_cd38}, {8'h5c, 32'h0012_3418, 32'h0012_3418},
                 {8'h30, 32'hffff_ffff, 32'h0}, {8'h08, 32'hffff_ffff, 32'h0},
                 {8'h10, 32'h0000_00ff, 32'h0000_00ff}};
        repeat (8) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        chk("crc reset", q, 32'h0);
        wb(1'b0, 8'h48, 32'h0);
        chk("ecr reset", q, 32'h00ff_ff00);
        foreach (rows[i]) begin
            {ra, rw, rx} = rows[i];
            wb(1'b1, ra, rw);
            wb(1'b0, ra, 32'h0);
            chk("register", q, rx);
        end
        wb(1'b1, 8'h0c, 32'h0000_ffff);
        wb(1'b1, 8'h44, 32'h0042_2118);
        clear_seen();
        i_dce_irq_src.fire(8'h21);
        idle(3);
        chk("start", {st, busy_o}, 16'h0202);
        clear_seen();
        i_dce_irq_src.fire(8'h42);
        idle(3);
        chk("abort", {ab, busy_o}, 16'h0200);
        wb(1'b0, 8'h04, 32'h0);
        chk("status", q, 32'h0000_0002);
        chk("status irq", irq_o, 1'b1);
        wb(1'b1, 8'h0c, 32'h0);
        idle(2);
        chk("irq mask", irq_o, 1'b0);
        wb(1'b1, 8'h08, 32'h2);
        wb(1'b0, 8'h04, 32'h0);
        chk("status clr", q, 32'h0);
        wb(1'b1, 8'h44, 32'h0042_2100);
        clear_seen();
        i_dce_irq_src.fire(8'h21);
        i_dce_irq_src.fire(8'h42);
        idle(3);
        chk("irq off", {st, ab}, 16'h0);
        wb(1'b1, 8'h4c, 32'h0055_5518);
        clear_seen();
        i_dce_irq_src.fire(8'h55);
        idle(3);
        chk("same cycle", {st[3], ab[3]}, 2'b01);
        clear_seen();
        wb(1'b1, 8'h48, 32'h80);
        idle(3);
        chk("force", st[2], 1'b1);
        wb(1'b1, 8'h48, 32'h40);
        idle(3);
        chk("sw abort", {ab[2], busy_o[2]}, 2'b10);
        clear_seen();
        sl = 4'he;
        wb(1'b1, 8'h48, 32'h80);
        sl = 4'hf;
        idle(3);
        chk("force lane", st[2], 1'b0);
        wb(1'b1, 8'h50, 32'ha0);
        wb(1'b1, 8'h54, 32'h80);
        clear_seen();
        pattern_match_i <= 8'h30;
        @(posedge clk_sys_i);
        pattern_match_i <= 8'h00;
        idle(3);
        chk("pattern", {ab[5:4], channel_enable_o[5:4]}, 4'b0110);
        wb(1'b1, 8'h00, 32'h40);
        clear_seen();
        feed(32'h1234_5678, 1'b1);
        idle(3);
        chk("append feed", flg, 4'b0001);
        chk("crc feed", crc_last, 32'h1234_5678);
        clear_seen();
        block_done_i <= 8'h01;
        @(posedge clk_sys_i);
        block_done_i <= 8'h00;
        idle(3);
        chk("append done", flg, 4'b0110);
        chk("crc written", dst_last, crc_result_i);
        wb(1'b1, 8'h00, 32'h80);
        feed(32'h1122_3344, 1'b1);
        idle(3);
        chk("byte order", dst_last, 32'h4433_2211);
        clear_seen();
        feed(32'h5566_7788, 1'b0);
        idle(3);
        chk("unaligned", flg, 4'b1000);
        clear_seen();
        src_chan_i <= 3'h3;
        feed(32'h99aa_bbcc, 1'b0);
        idle(3);
        chk("other chan", flg, 4'b0010);
        chk("other data", dst_last, 32'h99aa_bbcc);
        give_verdict();
    end
endmodule // tb_dce_event_ctrl
`default_nettype wire
